// ---- tpw_params.svh ----
// Constants for the 16-bit timer PWM generator: modes, fixed TOP values, field codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TPW_PARAMS_SVH
`define TPW_PARAMS_SVH

`define TPW_WGM_PC8      4'h1
`define TPW_WGM_PC9      4'h2
`define TPW_WGM_PC10     4'h3
`define TPW_WGM_FP8      4'h5
`define TPW_WGM_FP9      4'h6
`define TPW_WGM_FP10     4'h7
`define TPW_WGM_PC_CAP   4'ha
`define TPW_WGM_PC_CMPA  4'hb
`define TPW_WGM_FP_CAP   4'he
`define TPW_WGM_FP_CMPA  4'hf

`define TPW_TOP_8BIT     16'h00ff
`define TPW_TOP_9BIT     16'h01ff
`define TPW_TOP_10BIT    16'h03ff
`define TPW_MAX          16'hffff
`define TPW_BOTTOM       16'h0000
`define TPW_ONE          16'h0001

`define TPW_COM_OFF      2'h0
`define TPW_COM_TOGGLE   2'h1
`define TPW_COM_CLEAR    2'h2
`define TPW_COM_SET      2'h3

`define TPW_NCHAN        2

`endif

// ---- tpw_pkg.sv ----
// Types shared by the timer PWM generator modules.
// Assumes tpw_params.svh is reachable by bare name.
`include "tpw_params.svh"

`default_nettype none

package tpw_pkg;

    typedef enum logic [1:0] {
        TPW_KIND_OFF  = 2'h0,
        TPW_KIND_FAST = 2'h1,
        TPW_KIND_PC   = 2'h2
    } tpw_kind_t;

    typedef enum logic [1:0] {
        TPW_TOP_FIXED = 2'h0,
        TPW_TOP_CAP   = 2'h1,
        TPW_TOP_CMPA  = 2'h2
    } tpw_topsrc_t;

    // Decoded mode handed from the main block to the channel units.
    typedef struct packed {
        tpw_kind_t   kind;
        tpw_topsrc_t topsrc;
        logic [15:0] fixed_mask;
    } tpw_mode_t;

    // Per-count event strobes, valid only with the timer tick.
    typedef struct packed {
        logic        tick;
        logic        at_top;
        logic        at_bottom;
        logic        counting_up;
        logic [15:0] count;
    } tpw_cnt_ev_t;

    typedef struct packed {
        logic [15:0] buf_val;
        logic [15:0] act_val;
        logic        wave;
    } tpw_chan_state_t;

endpackage : tpw_pkg

`default_nettype wire

// ---- tpw_chan.sv ----
// One compare channel: buffered compare value, match detect and waveform level.
// Assumes event strobes from tpw_timer16_pwm, valid only together with the timer tick carried in ev.tick.
`include "tpw_params.svh"
`timescale 1ns/100ps
`default_nettype none

module tpw_chan (
    input  wire logic                 clk_sys,     // System clock, 125 MHz.
    input  wire logic                 rstn,        // Asynchronous reset, active low.
    input  wire tpw_pkg::tpw_mode_t   mode,        // Decoded waveform mode.
    input  wire tpw_pkg::tpw_cnt_ev_t ev,          // Counter events of this tick.
    input  wire logic [1:0]           action_mode, // Output action field.
    input  wire logic                 wr_en,       // Compare value write strobe.
    input  wire logic [15:0]          wr_data,     // Compare value write data.
    output logic [15:0]               act_value,   // Active compare value.
    output logic                      match,       // Match this tick, one cycle.
    output logic                      wave         // Waveform register level.
);
    tpw_pkg::tpw_chan_state_t s_q;
    tpw_pkg::tpw_chan_state_t s_d;
    logic                     hit;

    always_comb begin
        s_d = s_q;
        hit = ev.tick && mode.kind != tpw_pkg::TPW_KIND_OFF
              && (ev.count == s_q.act_val);
        if (wr_en) begin
            s_d.buf_val = wr_data & mode.fixed_mask;
        end
        if (ev.tick && ev.at_top && mode.kind != tpw_pkg::TPW_KIND_OFF) begin
            s_d.act_val = s_d.buf_val;
        end
        if (mode.kind == tpw_pkg::TPW_KIND_FAST && ev.tick) begin
            unique case (action_mode)
                `TPW_COM_TOGGLE: if (hit) s_d.wave = ~s_q.wave;
                `TPW_COM_CLEAR: begin
                    // Match wins over the wrap so that compare at TOP holds low.
                    if (hit) s_d.wave = 1'b0;
                    else if (ev.at_bottom) s_d.wave = 1'b1;
                end
                `TPW_COM_SET: begin
                    if (hit) s_d.wave = 1'b1;
                    else if (ev.at_bottom) s_d.wave = 1'b0;
                end
                default: s_d.wave = s_q.wave;
            endcase
        end else if (mode.kind == tpw_pkg::TPW_KIND_PC && ev.tick) begin
            unique case (action_mode)
                `TPW_COM_CLEAR: begin
                    if (hit) s_d.wave = ~ev.counting_up;
                    // Extreme values give steady levels.
                    if (s_q.act_val == `TPW_BOTTOM) s_d.wave = 1'b0;
                    else if (ev.at_top && hit) s_d.wave = 1'b1;
                end
                `TPW_COM_SET: begin
                    if (hit) s_d.wave = ev.counting_up;
                    if (s_q.act_val == `TPW_BOTTOM) s_d.wave = 1'b1;
                    else if (ev.at_top && hit) s_d.wave = 1'b0;
                end
                default: s_d.wave = s_q.wave;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign act_value = s_q.act_val;
    assign match     = hit;
    assign wave      = s_q.wave;

endmodule : tpw_chan

`default_nettype wire

// ---- tpw_timer16_pwm.sv ----
// 16-bit timer in fast PWM and phase correct PWM modes with two compare channels.
// Assumes a prescaled one-cycle tick from outside and synchronous control inputs.
`include "tpw_params.svh"
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Fixed TOP modes mask compare writes above active resolution to zero.
// - Capture TOP takes effect at once; below count means wrap through 0xFFFF.
// - Fast PWM compare writes go to buffer, loaded at TOP with overflow.
// - Fast PWM mode 2 clears on match, sets at wrap; 3 inverts.
// - Waveform reaches pin only when pin direction is output.
// - Fast PWM period is N times TOP plus one clock cycles.
// - Fast PWM compare zero gives spike; compare at TOP gives steady level.
// - Fast PWM channel A mode 1 toggles on match, buffering kept.
// - Modes 1,2,3,10,11 are phase correct, counting up then down.
// - Phase correct TOP is 0xFF, 0x1FF, 0x3FF, capture or compare A.
// - At TOP the counter holds one tick then reverses.
// - Register TOP supports resolutions from 2 up to 16 bits.
// - Phase correct sets overflow flag at every BOTTOM.
// - Phase correct loads buffers at TOP; sets compare A or capture flag.
// - Non-inverting phase correct clears on up match, sets on down match.
// - Phase correct mode 2 non-inverted, mode 3 inverted.
// - Phase correct period is 2 times N times TOP clock cycles.
// - Phase correct compare at BOTTOM steady low, at TOP steady high.
// - Compare flag set on every match; none when TOP below compare.
// - Modes 5,6,7,14,15 are fast PWM with matching TOP sources.
// - Fast PWM sets overflow at TOP, with compare A or capture flag.
module tpw_timer16_pwm (
    input  wire logic        clk_sys,                // System clock, 125 MHz.
    input  wire logic        rstn,                   // Asynchronous reset, active low.
    input  wire logic        timer_tick,             // Prescaled timer clock enable.
    input  wire logic [3:0]  waveform_mode_select,   // Waveform mode.
    input  wire logic [1:0]  output_action_mode_a,   // Channel A output action.
    input  wire logic [1:0]  output_action_mode_b,   // Channel B output action.
    input  wire logic        pin_direction_out_a,    // Pin A direction, 1 is output.
    input  wire logic        pin_direction_out_b,    // Pin B direction, 1 is output.
    input  wire logic        cmp_a_wr,               // Compare A write strobe.
    input  wire logic        cmp_b_wr,               // Compare B write strobe.
    input  wire logic        cap_top_wr,             // Capture register write strobe.
    input  wire logic [15:0] wr_data,                // Write data for the strobes.
    input  wire logic        flags_clr_ovf,          // Clear overflow flag.
    input  wire logic        flags_clr_cmp_a,        // Clear compare A flag.
    input  wire logic        flags_clr_cmp_b,        // Clear compare B flag.
    input  wire logic        flags_clr_cap,          // Clear capture flag.
    output logic [15:0]      timer_count,            // Current count.
    output logic [15:0]      compare_value_a,        // Active compare A.
    output logic [15:0]      compare_value_b,        // Active compare B.
    output logic [15:0]      capture_top_value,      // Capture register.
    output logic             overflow_flag,          // Sticky overflow flag.
    output logic             compare_flag_a,         // Sticky compare A flag.
    output logic             compare_flag_b,         // Sticky compare B flag.
    output logic             capture_flag,           // Sticky capture flag.
    output logic             wave_out_a,             // Pin A output data.
    output logic             wave_out_a_oe_n,        // Pin A enable, low drives.
    output logic             wave_out_b,             // Pin B output data.
    output logic             wave_out_b_oe_n         // Pin B enable, low drives.
);

    typedef struct packed {
        logic [15:0] count;
        logic        down;
        logic [15:0] cap_top;
        logic        ovf;
        logic        cf_a;
        logic        cf_b;
        logic        capf;
    } tpw_core_state_t;

    tpw_core_state_t       s_q;
    tpw_core_state_t       s_d;
    tpw_pkg::tpw_mode_t    mode;
    tpw_pkg::tpw_cnt_ev_t  ev;
    logic [15:0]           top;
    logic [15:0]           act_a;
    logic [15:0]           act_b;
    logic                  match_a;
    logic                  match_b;
    logic                  wave_a;
    logic                  wave_b;

    // Decodes the mode field into counting kind, TOP source and write mask.
    function automatic tpw_pkg::tpw_mode_t decode_mode(input logic [3:0] wgm);
        tpw_pkg::tpw_mode_t m;
        m.kind       = tpw_pkg::TPW_KIND_OFF;
        m.topsrc     = tpw_pkg::TPW_TOP_FIXED;
        m.fixed_mask = `TPW_MAX;
        unique case (wgm)
            `TPW_WGM_PC8, `TPW_WGM_PC9, `TPW_WGM_PC10,
            `TPW_WGM_PC_CAP, `TPW_WGM_PC_CMPA:
                m.kind = tpw_pkg::TPW_KIND_PC;
            `TPW_WGM_FP8, `TPW_WGM_FP9, `TPW_WGM_FP10,
            `TPW_WGM_FP_CAP, `TPW_WGM_FP_CMPA:
                m.kind = tpw_pkg::TPW_KIND_FAST;
            default: m.kind = tpw_pkg::TPW_KIND_OFF;
        endcase
        unique case (wgm)
            `TPW_WGM_PC8,  `TPW_WGM_FP8:  m.fixed_mask = `TPW_TOP_8BIT;
            `TPW_WGM_PC9,  `TPW_WGM_FP9:  m.fixed_mask = `TPW_TOP_9BIT;
            `TPW_WGM_PC10, `TPW_WGM_FP10: m.fixed_mask = `TPW_TOP_10BIT;
            `TPW_WGM_PC_CAP, `TPW_WGM_FP_CAP:   m.topsrc = tpw_pkg::TPW_TOP_CAP;
            `TPW_WGM_PC_CMPA, `TPW_WGM_FP_CMPA: m.topsrc = tpw_pkg::TPW_TOP_CMPA;
            default: m.fixed_mask = `TPW_MAX;
        endcase
        return m;
    endfunction : decode_mode

    assign mode = decode_mode(waveform_mode_select);

    // Register TOP allows any value from 0x0003 to full scale; the fixed mask
    // equals TOP in fixed modes.
    always_comb begin
        unique case (mode.topsrc)
            tpw_pkg::TPW_TOP_CAP:  top = s_q.cap_top;
            tpw_pkg::TPW_TOP_CMPA: top = act_a;
            default:               top = mode.fixed_mask;
        endcase
    end

    // A TOP below the count is never matched exactly, so the count runs to
    // full scale and wraps naturally, which is the documented hazard.
    always_comb begin
        ev.tick        = timer_tick;
        ev.count       = s_q.count;
        ev.counting_up = ~s_q.down;
        ev.at_top      = (s_q.count == top);
        if (mode.kind == tpw_pkg::TPW_KIND_FAST) begin
            ev.at_bottom = ev.at_top;
        end else begin
            ev.at_bottom = (s_q.count == `TPW_BOTTOM);
        end
    end

    always_comb begin
        s_d = s_q;
        if (cap_top_wr) begin
            s_d.cap_top = wr_data;
        end
        if (timer_tick && mode.kind == tpw_pkg::TPW_KIND_FAST) begin
            s_d.down = 1'b0;
            if (ev.at_top) begin
                s_d.count = `TPW_BOTTOM;
                s_d.ovf   = 1'b1;
            end else begin
                s_d.count = s_q.count + `TPW_ONE;
            end
        end else if (timer_tick && mode.kind == tpw_pkg::TPW_KIND_PC) begin
            if (ev.at_top && !s_q.down) begin
                // TOP is held for this tick and the count turns downward next.
                s_d.down  = 1'b1;
                s_d.count = s_q.count - `TPW_ONE;
            end else if (s_q.down && s_q.count == `TPW_BOTTOM) begin
                s_d.down  = 1'b0;
                s_d.count = s_q.count + `TPW_ONE;
            end else if (s_q.down) begin
                s_d.count = s_q.count - `TPW_ONE;
            end else begin
                s_d.count = s_q.count + `TPW_ONE;
            end
            if (s_q.count == `TPW_BOTTOM) begin
                s_d.ovf = 1'b1;
            end
        end
        // Clears act first so that a same-cycle event sets the flag again.
        if (flags_clr_ovf)   s_d.ovf  = 1'b0;
        if (flags_clr_cmp_a) s_d.cf_a = 1'b0;
        if (flags_clr_cmp_b) s_d.cf_b = 1'b0;
        if (flags_clr_cap)   s_d.capf = 1'b0;
        if (timer_tick && mode.kind == tpw_pkg::TPW_KIND_FAST && ev.at_top) begin
            s_d.ovf = 1'b1;
        end
        if (timer_tick && mode.kind == tpw_pkg::TPW_KIND_PC
            && s_q.count == `TPW_BOTTOM) begin
            s_d.ovf = 1'b1;
        end
        if (match_a) s_d.cf_a = 1'b1;
        if (match_b) s_d.cf_b = 1'b1;
        if (timer_tick && ev.at_top && mode.kind != tpw_pkg::TPW_KIND_OFF) begin
            if (mode.topsrc == tpw_pkg::TPW_TOP_CMPA) s_d.cf_a = 1'b1;
            if (mode.topsrc == tpw_pkg::TPW_TOP_CAP)  s_d.capf = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    tpw_chan u_chan_a (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .mode        (mode),
        .ev          (ev),
        .action_mode (output_action_mode_a),
        .wr_en       (cmp_a_wr),
        .wr_data     (wr_data),
        .act_value   (act_a),
        .match       (match_a),
        .wave        (wave_a)
    );

    // Toggle is a channel A feature only, so channel B sees it as no action.
    tpw_chan u_chan_b (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .mode        (mode),
        .ev          (ev),
        .action_mode ((output_action_mode_b == `TPW_COM_TOGGLE)
                      ? `TPW_COM_OFF : output_action_mode_b),
        .wr_en       (cmp_b_wr),
        .wr_data     (wr_data),
        .act_value   (act_b),
        .match       (match_b),
        .wave        (wave_b)
    );

    assign timer_count       = s_q.count;
    assign compare_value_a   = act_a;
    assign compare_value_b   = act_b;
    assign capture_top_value = s_q.cap_top;
    assign overflow_flag     = s_q.ovf;
    assign compare_flag_a    = s_q.cf_a;
    assign compare_flag_b    = s_q.cf_b;
    assign capture_flag      = s_q.capf;
    assign wave_out_a        = wave_a;
    assign wave_out_b        = wave_b;
    assign wave_out_a_oe_n   = ~pin_direction_out_a;
    assign wave_out_b_oe_n   = ~pin_direction_out_b;

endmodule : tpw_timer16_pwm

`default_nettype wire

// ---- tpw_timer16_pwm_properties.sv ----
// Concurrent checks on the 16-bit timer PWM generator, bound to its top module.
// Assumes one clock domain and the top module's port names.
`timescale 1ns/100ps
`default_nettype none

module tpw_timer16_pwm_props (
    input wire logic        clk_sys,              // System clock.
    input wire logic        rstn,                 // Reset, active low.
    input wire logic        timer_tick,           // Prescaled tick.
    input wire logic [3:0]  waveform_mode_select, // Waveform mode.
    input wire logic [1:0]  output_action_mode_a, // Channel A action.
    input wire logic        pin_direction_out_a,  // Pin A direction.
    input wire logic [15:0] timer_count,          // Count.
    input wire logic [15:0] compare_value_a,      // Active compare A.
    input wire logic [15:0] capture_top_value,    // Capture register.
    input wire logic        overflow_flag,        // Overflow flag.
    input wire logic        compare_flag_a,       // Compare A flag.
    input wire logic        capture_flag,         // Capture flag.
    input wire logic        wave_out_a,           // Waveform A.
    input wire logic        wave_out_a_oe_n       // Pin A enable.
);
    logic [15:0] top_w;
    logic        fast_w;
    logic        pc_w;
    logic        tt_w;

    always_comb begin
        fast_w = waveform_mode_select inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
        pc_w   = waveform_mode_select inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
        case (waveform_mode_select)
            4'h1, 4'h5: top_w = 16'h00ff;
            4'h2, 4'h6: top_w = 16'h01ff;
            4'h3, 4'h7: top_w = 16'h03ff;
            4'ha, 4'he: top_w = capture_top_value;
            default:    top_w = compare_value_a;
        endcase
        tt_w = timer_tick && (timer_count == top_w);
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    tick_gate_a: assert property (!timer_tick |=> $stable(timer_count))
        else $error("Count moved without a tick");
    pin_enable_a: assert property (wave_out_a_oe_n == !pin_direction_out_a)
        else $error("Pin A enable wrong");
    fast_wrap_a: assert property (fast_w && tt_w |=> timer_count == 16'h0000 && overflow_flag)
        else $error("Fast wrap missed");
    fast_step_a: assert property (fast_w && timer_tick && !tt_w |=>
        timer_count == $past(timer_count) + 16'h0001)
        else $error("Fast step wrong");
    pc_turn_a: assert property (pc_w && tt_w |=> timer_count == $past(timer_count) - 16'h0001)
        else $error("Turn at top wrong");
    pc_bottom_ovf_a: assert property (pc_w && timer_tick && timer_count == 16'h0000
        |=> overflow_flag)
        else $error("Bottom overflow missed");
    match_flag_a: assert property ((fast_w || pc_w) && timer_tick
        && timer_count == compare_value_a |=> compare_flag_a)
        else $error("Compare flag missed");
    fast_clear_a: assert property (fast_w && output_action_mode_a == 2'h2 && timer_tick
        && timer_count == compare_value_a |=> !wave_out_a)
        else $error("Fast clear missed");
    pc_zero_low_a: assert property (pc_w && output_action_mode_a == 2'h2 && timer_tick
        && compare_value_a == 16'h0000 |=> !wave_out_a)
        else $error("Zero compare not low");
    hold_active_a: assert property (!tt_w |=> $stable(compare_value_a))
        else $error("Compare loaded off top");
    cap_top_flag_a: assert property (waveform_mode_select inside {4'ha, 4'he} && tt_w
        |=> capture_flag)
        else $error("Capture flag missed");
endmodule : tpw_timer16_pwm_props

bind tpw_timer16_pwm tpw_timer16_pwm_props chk_u (
    .clk_sys(clk_sys), .rstn(rstn), .timer_tick(timer_tick),
    .waveform_mode_select(waveform_mode_select), .output_action_mode_a(output_action_mode_a),
    .pin_direction_out_a(pin_direction_out_a), .timer_count(timer_count),
    .compare_value_a(compare_value_a), .capture_top_value(capture_top_value),
    .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a),
    .capture_flag(capture_flag), .wave_out_a(wave_out_a), .wave_out_a_oe_n(wave_out_a_oe_n)
);

`default_nettype wire

// ---- tpw_pin_load.sv ----
// Load on the two compare output pins.
// Assumes the enable is low while the timer drives the pin.
`timescale 1ns/100ps
`default_nettype none

module tpw_pin_load (
    input  wire logic wave_a, // Timer data, pin A.
    input  wire logic oe_n_a, // Pin A enable, low drives.
    input  wire logic wave_b, // Timer data, pin B.
    input  wire logic oe_n_b, // Pin B enable, low drives.
    output logic      pin_a,  // Pin A level.
    output logic      pin_b   // Pin B level.
);
    // A released pin sits at the pull-up level, so it never shows stale data.
    assign pin_a = oe_n_a ? 1'b1 : wave_a;
    assign pin_b = oe_n_b ? 1'b1 : wave_b;
endmodule : tpw_pin_load

`default_nettype wire

// ---- tpw_timer16_pwm_tb.sv ----
// Self-checking bench for the 16-bit timer PWM generator.
// Assumes the checker is bound in and the pin load sits on both outputs.
`timescale 1ns/100ps
`default_nettype none

module tpw_timer16_pwm_tb;
    logic        clk_sys, rstn, timer_tick, tick_en, dir_a, clr_ovf, clr_a;
    logic [3:0]  mode;
    logic [1:0]  com_a, com_b;
    logic        cmp_a_wr, cmp_b_wr, cap_top_wr;
    logic [15:0] wr_data, cva, cvb;
    logic        ovf, cfa, cfb, capf, wa, wa_oe_n, wb, wb_oe_n, pin_a, pin_b;
    int          div, div_cnt, bad_count, total_checks;

    tpw_timer16_pwm dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .timer_tick(timer_tick),
        .waveform_mode_select(mode), .output_action_mode_a(com_a), .output_action_mode_b(com_b),
        .pin_direction_out_a(dir_a), .pin_direction_out_b(dir_a), .cmp_a_wr(cmp_a_wr),
        .cmp_b_wr(cmp_b_wr), .cap_top_wr(cap_top_wr), .wr_data(wr_data),
        .flags_clr_ovf(clr_ovf), .flags_clr_cmp_a(clr_a), .flags_clr_cmp_b(clr_a),
        .flags_clr_cap(clr_ovf), .timer_count(), .compare_value_a(cva), .compare_value_b(cvb),
        .capture_top_value(), .overflow_flag(ovf), .compare_flag_a(cfa), .compare_flag_b(cfb),
        .capture_flag(capf), .wave_out_a(wa), .wave_out_a_oe_n(wa_oe_n), .wave_out_b(wb),
        .wave_out_b_oe_n(wb_oe_n)
    );

    tpw_pin_load load_u (
        .wave_a(wa), .oe_n_a(wa_oe_n), .wave_b(wb), .oe_n_b(wb_oe_n), .pin_a(pin_a), .pin_b(pin_b)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Tick every div cycles while enabled; held off during set-up so writes land before counting.
    always @(posedge clk_sys) begin
        if (!tick_en || div_cnt >= div - 1) div_cnt <= 0;
        else div_cnt <= div_cnt + 1;
        timer_tick <= tick_en && (div_cnt >= div - 1);
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic stop_test;
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic rst;
        tick_en <= 1'b0;
        rstn    <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask : rst

    task automatic wr(input int sel, input logic [15:0] d);
        @(posedge clk_sys);
        cmp_a_wr   <= (sel == 0);
        cmp_b_wr   <= (sel == 1);
        cap_top_wr <= (sel == 2);
        wr_data    <= d;
        @(posedge clk_sys);
        cmp_a_wr   <= 1'b0;
        cmp_b_wr   <= 1'b0;
        cap_top_wr <= 1'b0;
    endtask : wr

    task automatic pulse_clr;
        @(posedge clk_sys);
        clr_ovf <= 1'b1;
        clr_a   <= 1'b1;
        @(posedge clk_sys);
        clr_ovf <= 1'b0;
        clr_a   <= 1'b0;
    endtask : pulse_clr

    // Counts high cycles over a window of whole periods, so the phase does not matter.
    task automatic run(input logic [3:0] m, input logic [1:0] c, input logic [15:0] ca, cb, cp,
                       input logic ch, input int dv, win, hi_exp);
        int hi;
        hi = 0;
        mode  <= m;
        com_a <= c;
        com_b <= c;
        div   <= dv;
        rst();
        wr(2, cp);
        wr(0, ca);
        wr(1, cb);
        tick_en <= 1'b1;
        repeat (2 * win + 4) @(posedge clk_sys);
        // Pins are sampled mid-cycle, where the registered levels have settled.
        repeat (win) begin
            @(negedge clk_sys);
            if ((ch ? pin_b : pin_a) === 1'b1) hi++;
        end
        @(posedge clk_sys);
        chk("high_time", 32'(hi_exp), 32'(hi));
    endtask : run

    initial begin
        repeat (95000) @(posedge clk_sys);
        bad_count++;
        stop_test();
    end

    initial begin
        {rstn, tick_en, cmp_a_wr, cmp_b_wr, cap_top_wr, clr_ovf, clr_a} = 7'h00;
        {mode, com_a, com_b, wr_data} = 24'h000000;
        dir_a = 1'b1;
        div = 1;
        bad_count = 0;
        total_checks = 0;
        run(4'h5, 2'h2, 16'h1234, 16'h0000, 16'h0000, 1'b0, 1, 256, 53);
        run(4'h5, 2'h3, 16'h0034, 16'h0000, 16'h0000, 1'b0, 1, 256, 203);
        run(4'h5, 2'h2, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1, 256, 1);
        run(4'h5, 2'h2, 16'h00ff, 16'h0000, 16'h0000, 1'b0, 1, 256, 0);
        run(4'h5, 2'h3, 16'h00ff, 16'h0000, 16'h0000, 1'b0, 1, 256, 256);
        run(4'h5, 2'h1, 16'h0010, 16'h0000, 16'h0000, 1'b0, 1, 512, 256);
        run(4'h6, 2'h2, 16'h0100, 16'h0000, 16'h0000, 1'b0, 1, 512, 257);
        run(4'h7, 2'h2, 16'hf200, 16'h0000, 16'h0000, 1'b0, 1, 1024, 513);
        run(4'h1, 2'h2, 16'h0040, 16'h0000, 16'h0000, 1'b0, 1, 510, 128);
        run(4'h1, 2'h3, 16'h0040, 16'h0000, 16'h0000, 1'b0, 1, 510, 382);
        run(4'h1, 2'h2, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1, 510, 0);
        run(4'h1, 2'h3, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1, 510, 510);
        run(4'h1, 2'h2, 16'h00ff, 16'h0000, 16'h0000, 1'b0, 1, 510, 510);
        run(4'h2, 2'h2, 16'h0040, 16'h0000, 16'h0000, 1'b0, 1, 1022, 128);
        run(4'ha, 2'h2, 16'h0000, 16'h0001, 16'h0003, 1'b1, 1, 6, 2);
        run(4'he, 2'h2, 16'h0000, 16'h0003, 16'h0007, 1'b1, 1, 8, 4);
        run(4'hf, 2'h3, 16'h000f, 16'h0005, 16'h0000, 1'b1, 8, 128, 80);
        mode  <= 4'h5;
        com_a <= 2'h2;
        div   <= 1;
        rst();
        wr(0, 16'h1234);
        wr(1, 16'h0345);
        tick_en <= 1'b1;
        #1 chk("cmp_a_active", 32'h0, 32'(cva));
        repeat (300) @(posedge clk_sys);
        #1 chk("cmp_a_active", 32'h34, 32'(cva));
        chk("cmp_b_active", 32'h45, 32'(cvb));
        chk("overflow_flag", 32'h1, 32'(ovf));
        chk("compare_flag_a", 32'h1, 32'(cfa));
        chk("compare_flag_b", 32'h1, 32'(cfb));
        pulse_clr();
        #1 chk("overflow_flag", 32'h0, 32'(ovf));
        chk("compare_flag_a", 32'h0, 32'(cfa));
        chk("compare_flag_b", 32'h0, 32'(cfb));
        repeat (256) @(posedge clk_sys);
        #1 chk("overflow_flag", 32'h1, 32'(ovf));
        chk("compare_flag_a", 32'h1, 32'(cfa));
        chk("compare_flag_b", 32'h1, 32'(cfb));
        @(posedge clk_sys);
        dir_a <= 1'b0;
        #1 chk("pin_a_enable", 32'h1, 32'(wa_oe_n));
        chk("pin_b_enable", 32'h1, 32'(wb_oe_n));
        @(posedge clk_sys);
        dir_a <= 1'b1;
        mode  <= 4'he;
        rst();
        wr(2, 16'h00ff);
        tick_en <= 1'b1;
        repeat (48) @(posedge clk_sys);
        wr(2, 16'h0010);
        pulse_clr();
        repeat (16'hff00) @(posedge clk_sys);
        #1 chk("overflow_flag", 32'h0, 32'(ovf));
        chk("capture_flag", 32'h0, 32'(capf));
        repeat (16'h0200) @(posedge clk_sys);
        #1 chk("overflow_flag", 32'h1, 32'(ovf));
        chk("capture_flag", 32'h1, 32'(capf));
        stop_test();
    end
endmodule : tpw_timer16_pwm_tb

`default_nettype wire
